/* qsf_pkg.sv */
package qsf_pkg;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WORD_READ = 8'he7;
   localparam logic [7:0] OP_SET_BURST = 8'h77;
   localparam logic [7:0] OP_SET_PARAMS = 8'hc0;
   localparam logic [7:0] OP_WRAP_READ = 8'h0c;
   localparam logic [7:0] OP_WRAP_READ_DDR = 8'h0e;
   localparam logic [7:0] OP_QCM_ENTER = 8'h38;
   localparam logic [7:0] OP_QCM_EXIT = 8'hff;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   localparam logic [7:0] LEARN_PATTERN = 8'h34;
   localparam logic [1:0] CONT_MODE_KEEP = 2'b10;
   localparam int WRAP_DISABLE_POS = 4;
   localparam int WRAP_SETTING_LSB = 5;
   localparam int DUMMY_FIELD_LSB = 4;
   localparam int WRAP_FIELD_LSB = 0;
   localparam logic [7:0] WRAP_BASE_BYTES = 8'h08;
   localparam logic [1:0] RESET_WRAP_LEN = 2'b00;
   localparam logic [1:0] RESET_DUMMY_SEL = 2'b00;
   localparam logic RESET_WRAP_DISABLE = 1'b1;
   localparam logic [5:0] CMD_SERIAL_CLKS = 6'h08;
   localparam logic [5:0] CMD_QUAD_CLKS = 6'h02;
   localparam logic [5:0] ADDR_QUAD_CLKS = 6'h06;
   localparam logic [5:0] MODE_QUAD_CLKS = 6'h02;
   localparam logic [5:0] WORD_READ_DUMMY = 6'h02;
   localparam logic [5:0] SET_BURST_CLKS = 6'h20;
   localparam logic [5:0] SET_PARAMS_CLKS = 6'h02;
   localparam logic [5:0] ERASE_SERIAL_CLKS = 6'h18;
   localparam logic [5:0] DDR_LEARN_CLKS = 6'h04;
   localparam int PAGE_BYTES = 256;
   localparam int CLK_MHZ = 20;
   localparam int ERASE_TIME_US = 1000;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   localparam int HOST_HALF_CYCLES = 8;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_TXD = 8'h04;
   localparam logic [7:0] REG_FMT = 8'h08;
   localparam logic [7:0] REG_GO = 8'h0c;
   localparam logic [7:0] REG_RXD = 8'h10;
   localparam int CMD_EN_POS = 8;
   localparam int CMD_QUAD_POS = 9;
   localparam int FMT_TXBITS_LSB = 0;
   localparam int FMT_TXQUAD_POS = 6;
   localparam int FMT_DUMMY_LSB = 8;
   localparam int FMT_RXBYTES_LSB = 12;
   localparam int FMT_DDR_POS = 20;

   function automatic logic [5:0] qsf_dummy_clocks(input logic [1:0] sel);
      case (sel)
         2'b00: qsf_dummy_clocks = 6'h0a;
         2'b01: qsf_dummy_clocks = 6'h04;
         2'b10: qsf_dummy_clocks = 6'h06;
         default: qsf_dummy_clocks = 6'h08;
      endcase
   endfunction
endpackage

/* qsf_if.sv */
`timescale 1ns/1ps
interface qsf_if;
   logic cs_n;
   logic sck;
   logic [3:0] h_io;
   logic h_oe;
   logic [3:0] d_io;
   logic d_oe;
   logic [3:0] io;
   // Pull-ups hold undriven lines high
   assign io = h_oe ? h_io : (d_oe ? d_io : 4'hf);
   modport host (output cs_n, output sck, output h_io, output h_oe, input io);
   modport dev (input cs_n, input sck, output d_io, output d_oe, input io);
endinterface

/* qsf_dev.sv */
// Summary of operation
// - Word read: even address, two dummy clocks
// - Byte address advances after each output byte
// - Word read needs quad enable bit set
// - Mode bits 10 skip next command byte
// - Wrap restarts at section start until deselect
// - Set burst stores enable and length bits
// - 24 dummy bits, wrap byte, low enables
// - Read parameters ignored in serial mode
// - Dummy field selects 10, 4, 6, 8
// - Wrap field selects 8 to 64 bytes
// - Reset gives 8-byte wrap, 10 dummies
// - Wrap length kept entering quad command mode
// - Host reprograms dummies after mode entry
// - Wrap read is fast read with wrap
// - Double-rate wrap read, both clock edges
// - Learning pattern driven in dummy cycles
// - Pattern only after mode-bit cycles
// - Pattern 00110100, excess bits dropped
// - Double rate: eight bits, last four dummies
// - Mode entry only with quad enable set
// - Mode switch keeps latch and wrap length
// - Exit command returns to serial mode
// - Page erase: latch, opcode, three bytes
`timescale 1ns/1ps
module qsf_dev #(
   parameter int PAGES = 2,
   parameter int ERASE_CYCLES = qsf_pkg::ERASE_CYCLES
) (
   qsf_if.dev LINK, // Flash link
   input wire logic CLK, // System clock
   input wire logic RESET, // Synchronous reset
   input wire logic QUAD_ENABLE_BIT, // Status quad enable
   input wire logic LEARNING_PATTERN_ENABLE, // Config bit 0
   output logic WRITE_ENABLE_LATCH, // Write enable latch
   output logic ERASE_BUSY, // Erase in progress
   output logic QUAD_COMMAND_MODE // Quad command mode active
);
   import qsf_pkg::*;
   localparam int MEM_BYTES = PAGES * PAGE_BYTES;
   localparam int AW = $clog2(MEM_BYTES);

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_CMD = 8'h02,
      ST_ADDR = 8'h04,
      ST_MODE = 8'h08,
      ST_DUMMY = 8'h10,
      ST_DATA = 8'h20,
      ST_ARG = 8'h40,
      ST_SKIP = 8'h80
   } qsf_dstate_t;

   function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic en,
                                             input logic [1:0] len);
      logic [7:0] mask;
      logic [23:0] inc;
      mask = (WRAP_BASE_BYTES << len) - 8'h01;
      inc = a + 24'h000001;
      if (en) begin
         wrap_next = {a[23:8], (a[7:0] & ~mask) | (inc[7:0] & mask)};
      end else begin
         wrap_next = inc;
      end
   endfunction

   function automatic logic pat_bit(input logic [2:0] i);
      pat_bit = LEARN_PATTERN[3'h7 - i];
   endfunction

   logic cs_s1, cs_s2, cs_q, sck_s1, sck_s2, sck_q;
   logic [3:0] io_s1, io_s2;
   qsf_dstate_t state;
   logic [7:0] op;
   logic wide, cont, ddr, qcm, write_enable_latch, wrap_dis, erase_arm, busy, nib, io_oe;
   logic [5:0] cnt, need;
   logic [31:0] sh, busy_cnt;
   logic [23:0] addr;
   logic [1:0] wrap_len, dummy_sel;
   logic [15:0] erase_page;
   logic [7:0] byte_q;
   logic [3:0] io_o;
   logic [7:0] mem [0:MEM_BYTES-1];

   // Pins are asynchronous to CLK
   always_ff @(posedge CLK) begin
      if (RESET) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_q <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_q <= 1'b0;
         io_s1 <= 4'hf;
         io_s2 <= 4'hf;
      end else begin
         cs_s1 <= LINK.cs_n;
         cs_s2 <= cs_s1;
         cs_q <= cs_s2;
         sck_s1 <= LINK.sck;
         sck_s2 <= sck_s1;
         sck_q <= sck_s2;
         io_s1 <= LINK.io;
         io_s2 <= io_s1;
      end
   end

   wire in_frame = !cs_s2;
   wire frame_start = !cs_s2 && cs_q;
   wire frame_end = cs_s2 && !cs_q;
   wire rise = in_frame && sck_s2 && !sck_q;
   wire fall = in_frame && !sck_s2 && sck_q;
   wire edge_out = fall || (ddr && rise);
   wire [31:0] next_sh = wide ? {sh[27:0], io_s2} : {sh[30:0], io_s2[0]};
   wire [5:0] cnt_inc = cnt + 6'h01;
   wire last = (cnt_inc == need);
   wire [7:0] opc = next_sh[7:0];
   wire acc_word = (opc == OP_WORD_READ) && !qcm && QUAD_ENABLE_BIT && !busy;
   wire acc_wrap = (opc == OP_WRAP_READ || opc == OP_WRAP_READ_DDR) && qcm && !busy;
   wire acc_burst = (opc == OP_SET_BURST) && !qcm;
   wire acc_params = (opc == OP_SET_PARAMS) && qcm;
   wire acc_erase = (opc == OP_PAGE_ERASE) && !busy;
   wire acc_enter = (opc == OP_QCM_ENTER) && !qcm && QUAD_ENABLE_BIT;
   wire acc_exit = (opc == OP_QCM_EXIT) && qcm;
   wire acc_write_enable_command = (opc == OP_WRITE_ENABLE) && !busy;
   // Word read follows the burst setting; wrap reads always wrap
   wire read_wrap = (op == OP_WORD_READ) ? !wrap_dis : 1'b1;
   wire [5:0] read_dummy = qsf_dummy_clocks(dummy_sel);
   wire erase_done = busy && (busy_cnt == 32'(ERASE_CYCLES - 1));
   wire [5:0] ddr_base = need - DDR_LEARN_CLKS;
   wire ddr_win = (cnt >= ddr_base);
   wire [5:0] ddr_idx = 6'((cnt - ddr_base) << 1);
   wire [2:0] ddr_pick = fall ? ddr_idx[2:0] : ddr_idx[2:0] + 3'h1;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state <= ST_IDLE;
         op <= 8'h00;
         wide <= 1'b0;
         cnt <= 6'h00;
         need <= 6'h00;
         sh <= 32'h00000000;
         addr <= 24'h000000;
         cont <= 1'b0;
         ddr <= 1'b0;
         qcm <= 1'b0;
         write_enable_latch <= 1'b0;
         wrap_dis <= RESET_WRAP_DISABLE;
         wrap_len <= RESET_WRAP_LEN;
         dummy_sel <= RESET_DUMMY_SEL;
         erase_arm <= 1'b0;
         erase_page <= 16'h0000;
      end else if (frame_start) begin
         sh <= 32'h00000000;
         cnt <= 6'h00;
         ddr <= 1'b0;
         if (cont) begin
            op <= OP_WORD_READ;
            wide <= 1'b1;
            need <= ADDR_QUAD_CLKS;
            state <= ST_ADDR;
         end else begin
            wide <= qcm;
            need <= qcm ? CMD_QUAD_CLKS : CMD_SERIAL_CLKS;
            state <= ST_CMD;
         end
      end else if (!in_frame) begin
         state <= ST_IDLE;
         ddr <= 1'b0;
         if (erase_done) begin
            write_enable_latch <= 1'b0;
         end
         if (frame_end) begin
            erase_arm <= 1'b0;
         end
      end else if (rise) begin
         sh <= next_sh;
         cnt <= cnt_inc;
         case (state)
            ST_CMD: if (last) begin
               cnt <= 6'h00;
               sh <= 32'h00000000;
               op <= opc;
               if (acc_word || acc_wrap) begin
                  wide <= 1'b1;
                  need <= ADDR_QUAD_CLKS;
                  ddr <= (opc == OP_WRAP_READ_DDR);
                  state <= ST_ADDR;
               end else if (acc_burst) begin
                  wide <= 1'b0;
                  need <= SET_BURST_CLKS;
                  state <= ST_ARG;
               end else if (acc_params) begin
                  wide <= 1'b1;
                  need <= SET_PARAMS_CLKS;
                  state <= ST_ARG;
               end else if (acc_erase) begin
                  wide <= qcm;
                  need <= qcm ? ADDR_QUAD_CLKS : ERASE_SERIAL_CLKS;
                  state <= ST_ARG;
               end else begin
                  state <= ST_SKIP;
                  // Mode entry and exit leave latch and wrap state untouched
                  if (acc_enter) begin
                     qcm <= 1'b1;
                  end
                  if (acc_exit) begin
                     qcm <= 1'b0;
                  end
                  if (acc_write_enable_command) begin
                     write_enable_latch <= 1'b1;
                  end
               end
            end
            ST_ADDR: if (last) begin
               cnt <= 6'h00;
               addr <= next_sh[23:0];
               if (op == OP_WORD_READ) begin
                  need <= MODE_QUAD_CLKS;
                  state <= ST_MODE;
               end else begin
                  need <= read_dummy;
                  state <= ST_DUMMY;
               end
            end
            ST_MODE: if (last) begin
               cnt <= 6'h00;
               cont <= (next_sh[5:4] == CONT_MODE_KEEP);
               need <= WORD_READ_DUMMY;
               state <= ST_DUMMY;
            end
            ST_DUMMY: if (last) begin
               state <= ST_DATA;
            end
            ST_ARG: if (last) begin
               state <= ST_SKIP;
               if (op == OP_SET_BURST) begin
                  wrap_dis <= next_sh[WRAP_DISABLE_POS];
                  wrap_len <= next_sh[WRAP_SETTING_LSB +: 2];
               end else if (op == OP_SET_PARAMS) begin
                  dummy_sel <= next_sh[DUMMY_FIELD_LSB +: 2];
                  wrap_len <= next_sh[WRAP_FIELD_LSB +: 2];
               end else begin
                  erase_page <= next_sh[23:8];
                  erase_arm <= write_enable_latch;
               end
            end
            ST_DATA: state <= ST_DATA;
            // Extra clocks past the last byte cancel an erase
            ST_SKIP: erase_arm <= 1'b0;
            default: state <= ST_SKIP;
         endcase
      end else if (state == ST_DATA && edge_out && !nib) begin
         addr <= wrap_next(addr, read_wrap, wrap_len);
      end
   end

   // Erase timer runs from deselect
   always_ff @(posedge CLK) begin
      if (RESET) begin
         busy <= 1'b0;
         busy_cnt <= 32'h00000000;
      end else if (frame_end && erase_arm && !busy) begin
         busy <= 1'b1;
         busy_cnt <= 32'h00000000;
      end else if (erase_done) begin
         busy <= 1'b0;
      end else if (busy) begin
         busy_cnt <= busy_cnt + 32'h00000001;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= 8'(i);
         end
      end else if (erase_done) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            if (i / PAGE_BYTES == int'(erase_page)) begin
               mem[i] <= 8'hff;
            end
         end
      end
   end

   // Output changes on falling edges, plus rising edges in double rate; single rate host samples on rising
   always_ff @(posedge CLK) begin
      if (RESET) begin
         io_o <= 4'h0;
         io_oe <= 1'b0;
         byte_q <= 8'h00;
         nib <= 1'b0;
      end else if (!in_frame) begin
         io_oe <= 1'b0;
         nib <= 1'b0;
      end else if (state == ST_DUMMY && edge_out) begin
         if (!LEARNING_PATTERN_ENABLE) begin
            io_oe <= 1'b0;
         end else if (!ddr) begin
            io_oe <= (cnt < 6'h08);
            io_o <= {4{pat_bit(cnt[2:0])}};
         end else begin
            io_oe <= ddr_win;
            io_o <= {4{pat_bit(ddr_pick)}};
         end
      end else if (state == ST_DATA && edge_out) begin
         io_oe <= 1'b1;
         nib <= !nib;
         if (!nib) begin
            byte_q <= mem[addr[AW-1:0]];
            io_o <= mem[addr[AW-1:0]][7:4];
         end else begin
            io_o <= byte_q[3:0];
         end
      end
   end

   assign LINK.d_io = io_o;
   assign LINK.d_oe = io_oe;
   assign WRITE_ENABLE_LATCH = write_enable_latch;
   assign ERASE_BUSY = busy;
   assign QUAD_COMMAND_MODE = qcm;
endmodule

/* qsf_host.sv */
`timescale 1ns/1ps
module qsf_host #(
   parameter int HALF = qsf_pkg::HOST_HALF_CYCLES
) (
   qsf_if.host LINK, // Flash link
   input wire logic CLK, // System clock
   input wire logic RESET, // Synchronous reset
   input wire logic [7:0] ADDR, // Register address
   input wire logic [31:0] WDATA, // Write data
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   output logic [31:0] RDATA // Read data, cycle after RD
);
   import qsf_pkg::*;

   typedef enum logic [6:0] {
      H_IDLE = 7'h01,
      H_CMD = 7'h02,
      H_TX = 7'h04,
      H_DUM = 7'h08,
      H_RX = 7'h10,
      H_END = 7'h20,
      H_GAP = 7'h40
   } qsf_hstate_t;

   logic [7:0] cmd_op, rx_byte, div;
   logic cmd_en, cmd_quad, tx_quad, rx_ddr, rx_flag, rx_go, nib, quad, cs_n, sck, oe;
   logic [31:0] txd, sh;
   logic [5:0] tx_bits;
   logic [3:0] dummy, rx_hi, out_q, io_s1, io_s2;
   logic [7:0] rx_bytes;
   logic [8:0] left;
   qsf_hstate_t state;

   // Segment order realises command skip, address, mode, dummies, data
   function automatic qsf_hstate_t seg_after(input qsf_hstate_t s);
      if (s == H_IDLE && cmd_en) begin
         seg_after = H_CMD;
      end else if ((s == H_IDLE || s == H_CMD) && tx_bits != 6'h00) begin
         seg_after = H_TX;
      end else if (s != H_DUM && s != H_RX && dummy != 4'h0) begin
         seg_after = H_DUM;
      end else if (s != H_RX && rx_bytes != 8'h00) begin
         seg_after = H_RX;
      end else begin
         seg_after = H_END;
      end
   endfunction

   function automatic logic [8:0] seg_len(input qsf_hstate_t s);
      case (s)
         H_CMD: seg_len = cmd_quad ? 9'h002 : 9'h008;
         H_TX: seg_len = {3'h0, tx_quad ? {2'b00, tx_bits[5:2]} : tx_bits};
         H_DUM: seg_len = {5'h00, dummy};
         H_RX: seg_len = {rx_bytes, 1'b0};
         default: seg_len = 9'h001;
      endcase
   endfunction

   function automatic logic [3:0] top(input logic [31:0] v, input logic q);
      top = q ? v[31:28] : {3'b111, v[31]};
   endfunction

   wire tick = (div == 8'(HALF - 1));
   qsf_hstate_t first, nxt;
   // Functions read config registers, so a process tracks them
   always_comb begin
      first = seg_after(H_IDLE);
      nxt = seg_after(state);
   end
   wire [31:0] first_sh = (first == H_CMD) ? {cmd_op, 24'h000000} : txd;
   wire first_q = (first == H_CMD) ? cmd_quad : tx_quad;
   wire go = WR && (ADDR == REG_GO) && (state == H_IDLE);
   wire sample = (state == H_RX) && tick && (!sck || (rx_ddr && rx_go));
   wire rx_done = sample && nib;
   wire rd_rxd = RD && (ADDR == REG_RXD);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         io_s1 <= 4'hf;
         io_s2 <= 4'hf;
      end else begin
         io_s1 <= LINK.io;
         io_s2 <= io_s1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state <= H_IDLE;
         cs_n <= 1'b1;
         sck <= 1'b0;
         div <= 8'h00;
         left <= 9'h000;
         sh <= 32'h00000000;
         quad <= 1'b0;
         out_q <= 4'hf;
         oe <= 1'b0;
         rx_go <= 1'b0;
         nib <= 1'b0;
         rx_hi <= 4'h0;
      end else if (state == H_IDLE) begin
         div <= 8'h00;
         if (go) begin
            cs_n <= 1'b0;
            sck <= 1'b0;
            state <= first;
            left <= seg_len(first);
            sh <= first_sh;
            quad <= first_q;
            out_q <= top(first_sh, first_q);
            oe <= (first == H_CMD || first == H_TX);
            rx_go <= 1'b0;
            nib <= 1'b0;
         end
      end else begin
         div <= tick ? 8'h00 : div + 8'h01;
         if (tick) begin
            case (state)
               H_END: begin
                  oe <= 1'b0;
                  if (sck) begin
                     sck <= 1'b0;
                  end else begin
                     cs_n <= 1'b1;
                     state <= H_GAP;
                  end
               end
               H_GAP: state <= H_IDLE;
               H_RX: begin
                  sck <= !sck;
                  if (!sck) begin
                     rx_go <= 1'b1;
                  end
                  if (sample) begin
                     nib <= !nib;
                     rx_hi <= io_s2;
                     left <= left - 9'h001;
                     if (left == 9'h001) begin
                        state <= H_END;
                     end
                  end
               end
               default: begin
                  sck <= !sck;
                  if (!sck && left == 9'h001) begin
                     state <= nxt;
                     left <= seg_len(nxt);
                     sh <= txd;
                     quad <= tx_quad;
                  end else if (!sck) begin
                     left <= left - 9'h001;
                     sh <= quad ? {sh[27:0], 4'h0} : {sh[30:0], 1'b0};
                  end else begin
                     out_q <= top(sh, quad);
                     oe <= (state == H_CMD || state == H_TX);
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rx_byte <= 8'h00;
         rx_flag <= 1'b0;
      end else if (rx_done) begin
         rx_byte <= {rx_hi, io_s2};
         rx_flag <= 1'b1;
      end else if (rd_rxd) begin
         rx_flag <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         cmd_op <= 8'h00;
         cmd_en <= 1'b0;
         cmd_quad <= 1'b0;
         txd <= 32'h00000000;
         tx_bits <= 6'h00;
         tx_quad <= 1'b0;
         dummy <= 4'h0;
         rx_bytes <= 8'h00;
         rx_ddr <= 1'b0;
      end else if (WR && ADDR == REG_CMD) begin
         cmd_op <= WDATA[7:0];
         cmd_en <= WDATA[CMD_EN_POS];
         cmd_quad <= WDATA[CMD_QUAD_POS];
      end else if (WR && ADDR == REG_TXD) begin
         txd <= WDATA;
      end else if (WR && ADDR == REG_FMT) begin
         tx_bits <= WDATA[FMT_TXBITS_LSB +: 6];
         tx_quad <= WDATA[FMT_TXQUAD_POS];
         dummy <= WDATA[FMT_DUMMY_LSB +: 4];
         rx_bytes <= WDATA[FMT_RXBYTES_LSB +: 8];
         rx_ddr <= WDATA[FMT_DDR_POS];
      end
   end

   wire [31:0] rd_mux = (ADDR == REG_CMD) ? {22'h000000, cmd_quad, cmd_en, cmd_op} :
                        (ADDR == REG_TXD) ? txd :
                        (ADDR == REG_FMT) ? {11'h000, rx_ddr, rx_bytes, dummy, 1'b0, tx_quad,
                                             tx_bits} :
                        (ADDR == REG_GO) ? {30'h00000000, rx_flag, state != H_IDLE} :
                        (ADDR == REG_RXD) ? {24'h000000, rx_byte} : 32'h00000000;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         RDATA <= 32'h00000000;
      end else if (RD) begin
         RDATA <= rd_mux;
      end
   end

   assign LINK.cs_n = cs_n;
   assign LINK.sck = sck;
   assign LINK.h_io = out_q;
   assign LINK.h_oe = oe;
endmodule

/* qsf_assertions.sv */
`timescale 1ns/1ps
module qsf_assertions (
   input wire logic CLK, // Clock
   input wire logic RESET, // Reset
   input wire logic cs_n, // Select
   input wire logic sck, // Link clock
   input wire logic h_oe, // Host drives
   input wire logic d_oe // Device drives
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   io_fight_a: assert property (!(h_oe && d_oe)) else $error("io fight");
   sck_parked_a: assert property (cs_n |-> !sck) else $error("sck idle");
   sck_high_a: assert property ($rose(sck) |-> sck[*8] ##1 !sck) else $error("sck high");
   sck_low_a: assert property ($fell(sck) |-> !sck[*8]) else $error("sck low");
   cs_gap_a: assert property ($rose(cs_n) |-> cs_n[*8]) else $error("cs gap");
   cs_start_a: assert property ($fell(cs_n) |-> h_oe && !sck) else $error("cs start");
   dev_release_a: assert property (cs_n[*5] |-> !d_oe) else $error("dev release");
   dev_launch_a: assert property ($rose(d_oe) |-> !cs_n && !sck) else $error("dev launch");
   cover property ($rose(d_oe));
   cover property ($fell(cs_n));
   cover property (d_oe && sck);
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   import qsf_pkg::*;
   logic clk = 0, reset = 1, qe = 0, lpe = 0, wr = 0, rd = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] rise_trace = 32'h0;
   logic write_enable_latch, busy, qcm;
   int fail_count = 0, checked = 0;
   qsf_if link();
   qsf_host qsf_host_i (.LINK(link), .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata));
   qsf_dev #(.ERASE_CYCLES(20)) qsf_dev_i (.LINK(link), .CLK(clk), .RESET(reset),
      .QUAD_ENABLE_BIT(qe), .LEARNING_PATTERN_ENABLE(lpe), .WRITE_ENABLE_LATCH(write_enable_latch),
      .ERASE_BUSY(busy), .QUAD_COMMAND_MODE(qcm));
   qsf_assertions qsf_assertions_i (.CLK(clk), .RESET(reset), .cs_n(link.cs_n),
      .sck(link.sck), .h_oe(link.h_oe), .d_oe(link.d_oe));
   // Line 0 as seen at every link clock rise
   always @(posedge link.sck) rise_trace <= {rise_trace[30:0], link.io[0]};
   initial forever #25 clk = ~clk;
   task automatic end_sim;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // No receive buffer, so each byte is fetched before the next lands
   task automatic frame(input logic [31:0] c, t, f, e);
      logic [31:0] v;
      int n;
      n = f[19:12];
      wrr(REG_CMD, c);
      wrr(REG_TXD, t);
      wrr(REG_FMT, f);
      wrr(REG_GO, 32'h1);
      for (int i = 0; i < n; i++) begin
         v = 32'h0;
         for (int k = 0; k < 600 && v[1] !== 1'b1; k++) rdr(REG_GO, v);
         cmp({7'h0, v[1]}, 8'h01);
         rdr(REG_RXD, v);
         cmp(v[7:0], e[31-8*i -: 8]);
      end
      v = 32'h1;
      for (int k = 0; k < 600 && v[0] !== 1'b0; k++) rdr(REG_GO, v);
      cmp({7'h0, v[0]}, 8'h00);
   endtask
   task automatic test_word_read;
      frame(32'h1e7, 32'h00003c00, 32'h1260, 32'hff000000);
      @(posedge clk) qe <= 1'b1;
      frame(32'h1e7, 32'h00003e20, 32'h4260, 32'h3e3f4041);
      frame(32'h000, 32'h00001000, 32'h2260, 32'h10110000);
      frame(32'h1e7, 32'h00002000, 32'h1260, 32'h20000000);
      $display("test_word_read done");
   endtask
   task automatic test_wrap;
      logic [7:0] a;
      for (int s = 0; s < 4; s++) begin
         a = 8'h3e + (8'h08 << s);
         frame(32'h177, {24'h0, 1'b0, s[1:0], 5'h00}, 32'h20, 32'h0);
         frame(32'h1e7, {16'h0, a, 8'h00}, 32'h4260, {a, a + 8'h01, 16'h4041});
      end
      $display("test_wrap done");
   endtask
   task automatic test_quad;
      frame(32'h1c0, 32'h11000000, 32'h08, 32'h0);
      frame(32'h106, 32'h0, 32'h0, 32'h0);
      @(posedge clk) qe <= 1'b0;
      frame(32'h138, 32'h0, 32'h0, 32'h0);
      cmp({6'h0, write_enable_latch, qcm}, 8'h02);
      @(posedge clk) qe <= 1'b1;
      lpe <= 1'b1;
      frame(32'h138, 32'h0, 32'h0, 32'h0);
      cmp({6'h0, write_enable_latch, qcm}, 8'h03);
      frame(32'h30c, 32'h00007e00, 32'h4a58, 32'h7e7f4041);
      cmp(rise_trace[17:10], LEARN_PATTERN);
      cmp({6'h0, rise_trace[9:8]}, 8'h03);
      frame(32'h3c0, 32'h11000000, 32'h48, 32'h0);
      frame(32'h30c, 32'h00007e00, 32'h4458, 32'h7e7f7071);
      cmp({4'h0, rise_trace[11:8]}, {4'h0, LEARN_PATTERN[7:4]});
      frame(32'h30e, 32'h00005e00, 32'h104458, 32'h5e5f5051);
      frame(32'h3ff, 32'h0, 32'h0, 32'h0);
      cmp({6'h0, write_enable_latch, qcm}, 8'h02);
      $display("test_quad done");
   endtask
   task automatic test_erase;
      frame(32'h181, 32'h00010000, 32'h18, 32'h0);
      cmp({6'h0, write_enable_latch, busy}, 8'h03);
      repeat (30) @(posedge clk);
      cmp({6'h0, write_enable_latch, busy}, 8'h00);
      frame(32'h1e7, 32'h00010200, 32'h2260, 32'hffff0000);
      frame(32'h181, 32'h00000000, 32'h18, 32'h0);
      cmp({6'h0, write_enable_latch, busy}, 8'h00);
      frame(32'h1e7, 32'h00000200, 32'h1260, 32'h02000000);
      $display("test_erase done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1 cmp({5'h0, write_enable_latch, busy, qcm}, 8'h00);
      test_word_read;
      test_wrap;
      test_quad;
      test_erase;
      end_sim;
   end
   // Whole run needs about 10000 cycles
   initial begin
      repeat (80000) @(posedge clk);
      fail_count++;
      end_sim;
   end
endmodule
